// file: core/mas_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the core and its divider
`ifndef MAS_REGS_SVH
`define MAS_REGS_SVH

// ==========================================================
// register indices; byte address is four times the index
`define MAS_IDX_FMT 6'h04
`define MAS_IDX_CMP 6'h05
`define MAS_IDX_CLK 6'h06
`define MAS_IDX_ADD 6'h07
`define MAS_IDX_STAT 6'h08

// ==========================================================
// serial_port_format_control fields
`define MAS_FMT_DUP_BIT 9
`define MAS_FMT_BINV_BIT 8
`define MAS_FMT_SPOL_BIT 7
`define MAS_FMT_WL_HI 6
`define MAS_FMT_WL_LO 5
`define MAS_FMT_SEL_HI 4
`define MAS_FMT_SEL_LO 3
`define MAS_FMT_SWAP_BIT 1
`define MAS_FMT_RESET 10'h050

// companding_control fields
`define MAS_CMP_BYTE_BIT 5
`define MAS_CMP_RESET 9'h000

// clock_generation_control fields
`define MAS_CLK_SRC_BIT 8
`define MAS_CLK_CDIV_HI 7
`define MAS_CLK_CDIV_LO 5
`define MAS_CLK_BDIV_HI 4
`define MAS_CLK_BDIV_LO 2
`define MAS_CLK_MS_BIT 0
`define MAS_CLK_RESET 9'h140

// additional_control fields
`define MAS_ADD_RATE_HI 3
`define MAS_ADD_RATE_LO 1
`define MAS_ADD_RESET 9'h000

// ==========================================================
// core clock edges per frame half at 256fs
`define MAS_HALF_FRAME_EDGES 9'h100
`define MAS_RATE_LAST 3'h5

`endif

// file: core/mas_pkg.sv
// types shared by the core and its divider
// assumes nothing beyond the register header
package mas_pkg;

    // ==========================================================
    // data formats
    typedef enum logic [1:0] {
        MAS_FMT_RJ,
        MAS_FMT_LJ,
        MAS_FMT_I2S,
        MAS_FMT_DSP
    } mas_fmt_type;

    // ==========================================================
    // divider state
    typedef struct packed {
        logic [4:0] acc;
        logic tick;
    } mas_div_state_type;

endpackage

// file: core/mas_core_div.sv
// core clock selection and fractional division into edge ticks
// assumes one-cycle source ticks, one per source clock edge
`timescale 1ns/1ps
`include "mas_regs.svh"

module mas_core_div import mas_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mclk_tick,
    input wire logic pll_tick,
    input wire logic src_pll,
    input wire logic [2:0] div_code,
    output logic core_tick
);

    // ==========================================================
    // ratio in half units keeps 1.5 exact
    function automatic logic [4:0] half_div(input logic [2:0] code);
        case (code)
            3'h0: half_div = 5'h02;
            3'h1: half_div = 5'h03;
            3'h2: half_div = 5'h04;
            3'h3: half_div = 5'h06;
            3'h4: half_div = 5'h08;
            3'h5: half_div = 5'h0C;
            3'h6: half_div = 5'h10;
            default: half_div = 5'h18;
        endcase
    endfunction

    // ==========================================================
    // state
    mas_div_state_type s_q, s_d;
    logic src_tick;
    logic [4:0] sum;

    always_comb begin
        s_d = s_q;
        src_tick = src_pll ? pll_tick : mclk_tick;
        sum = s_q.acc + 5'h02;
        s_d.tick = 1'b0;
        if (src_tick) begin
            // 1.5 gives two ticks out of three, unevenly spaced
            if (sum >= half_div(div_code)) begin
                s_d.acc = sum - half_div(div_code);
                s_d.tick = 1'b1;
            end else begin
                s_d.acc = sum;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign core_tick = s_q.tick;

endmodule

// file: core/mas_serial_core.sv
// mono adc serial port with clock generation and rate setting
// assumes classic wishbone master, pins synchronous to clk,
// and source clock ticks, one pulse per clock edge
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "mas_regs.svh"

module mas_serial_core import mas_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic master_clock_tick,
    input wire logic pll_clock_tick,
    input wire logic [31:0] adc_sample,
    output logic sample_taken,
    input wire logic bit_clock_i,
    output logic bit_clock_o,
    output logic bit_clock_oe_n,
    input wire logic word_sync_i,
    output logic word_sync_o,
    output logic word_sync_oe_n,
    output logic serial_sample_out,
    output logic [2:0] filter_rate_sel,
    output logic filter_rate_reserved
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [9:0] fmt_reg;
        logic [8:0] cmp_reg;
        logic [8:0] clk_reg;
        logic [8:0] add_reg;
        logic ack;
        logic [31:0] rdat;
        logic [4:0] bdiv_cnt;
        logic [8:0] edge_cnt;
        logic mbclk;
        logic mframe;
        logic dsp_pulse;
        logic bclk_prev;
        logic frame_prev;
        logic [9:0] cnt;
        logic [9:0] half_len;
        logic right;
        logic [31:0] sample;
        logic sout;
        logic taken;
        logic [2:0] rate;
        logic rate_bad;
    } mas_core_state_type;

    mas_core_state_type s_q, s_d;

    // ==========================================================
    // helpers
    function automatic logic [5:0] word_bits(input logic [1:0] wl,
                                             input logic byte_ovr,
                                             input mas_fmt_type fmt);
        if (byte_ovr) begin
            word_bits = 6'h08;
        end else begin
            case (wl)
                2'h0: word_bits = 6'h10;
                2'h1: word_bits = 6'h14;
                2'h2: word_bits = 6'h18;
                default: word_bits = (fmt == MAS_FMT_RJ) ? 6'h18 : 6'h20;
            endcase
        end
    endfunction

    // reserved divider codes fall back to the slowest ratio
    function automatic logic [4:0] bit_half_period(input logic [2:0] code);
        case (code)
            3'h0: bit_half_period = 5'h00;
            3'h1: bit_half_period = 5'h01;
            3'h2: bit_half_period = 5'h03;
            3'h3: bit_half_period = 5'h07;
            3'h4: bit_half_period = 5'h0F;
            default: bit_half_period = 5'h1F;
        endcase
    endfunction

    // ==========================================================
    // decoded controls
    logic master;
    logic binv;
    logic spol;
    logic swap;
    logic dup;
    mas_fmt_type fmt;
    logic [5:0] wlen;
    logic core_tick;
    logic req;
    logic [5:0] idx;
    logic [31:0] rsel;

    assign master = s_q.clk_reg[`MAS_CLK_MS_BIT];
    assign binv = s_q.fmt_reg[`MAS_FMT_BINV_BIT];
    assign spol = s_q.fmt_reg[`MAS_FMT_SPOL_BIT];
    assign swap = s_q.fmt_reg[`MAS_FMT_SWAP_BIT];
    assign dup = s_q.fmt_reg[`MAS_FMT_DUP_BIT];
    assign fmt = mas_fmt_type'(s_q.fmt_reg[`MAS_FMT_SEL_HI:`MAS_FMT_SEL_LO]);
    assign wlen = word_bits(s_q.fmt_reg[`MAS_FMT_WL_HI:`MAS_FMT_WL_LO],
                            s_q.cmp_reg[`MAS_CMP_BYTE_BIT], fmt);
    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[7:2];

    // ==========================================================
    // core clock source and divider
    mas_core_div u_div (
        .clk(clk),
        .reset_n(reset_n),
        .mclk_tick(master_clock_tick),
        .pll_tick(pll_clock_tick),
        .src_pll(s_q.clk_reg[`MAS_CLK_SRC_BIT]),
        .div_code(s_q.clk_reg[`MAS_CLK_CDIV_HI:`MAS_CLK_CDIV_LO]),
        .core_tick(core_tick)
    );

    // ==========================================================
    // internal clock levels, slave pin polarity removed
    logic bclk;
    logic frame;
    logic fall;
    logic new_phase;
    logic [9:0] pos;
    logic [9:0] cnt_n;
    logic valid;
    logic slot_right;
    logic active;

    always_comb begin
        if (master) begin
            bclk = s_q.mbclk;
            frame = (fmt == MAS_FMT_DSP) ? s_q.dsp_pulse : s_q.mframe;
        end else begin
            bclk = bit_clock_i ^ binv;
            frame = (fmt == MAS_FMT_DSP) ? word_sync_i : (word_sync_i ^ spol);
        end
    end

    assign fall = s_q.bclk_prev & ~bclk;

    // ==========================================================
    // position of the coming bit in its phase
    always_comb begin
        if (fmt == MAS_FMT_DSP) begin
            new_phase = frame & ~s_q.frame_prev;
        end else begin
            new_phase = frame ^ s_q.frame_prev;
        end
        cnt_n = new_phase ? 10'h000 : (s_q.cnt + 10'h001);
        valid = 1'b0;
        slot_right = new_phase ? ((fmt == MAS_FMT_I2S) ? frame : ~frame) : s_q.right;
        pos = 10'h000;
        case (fmt)
            MAS_FMT_LJ: begin
                pos = cnt_n;
                valid = cnt_n < {4'h0, wlen};
            end
            MAS_FMT_I2S: begin
                pos = cnt_n - 10'h001;
                valid = (cnt_n != 10'h000) && (pos < {4'h0, wlen});
            end
            MAS_FMT_RJ: begin
                // phase length learned from the last phase
                pos = cnt_n + {4'h0, wlen} - s_q.half_len;
                valid = (cnt_n + {4'h0, wlen} >= s_q.half_len) &&
                        (cnt_n < s_q.half_len);
            end
            MAS_FMT_DSP: begin
                pos = spol ? cnt_n : (cnt_n - 10'h001);
                valid = spol || (cnt_n != 10'h000);
                slot_right = pos >= {4'h0, wlen};
                if (slot_right) begin
                    pos = pos - {4'h0, wlen};
                end
                valid = valid && (pos < {4'h0, wlen});
            end
            default: begin
                valid = 1'b0;
            end
        endcase
        active = valid && (dup || (slot_right == swap));
    end

    // ==========================================================
    // register read mux
    always_comb begin
        case (idx)
            `MAS_IDX_FMT: rsel = {22'h000000, s_q.fmt_reg};
            `MAS_IDX_CMP: rsel = {23'h000000, s_q.cmp_reg};
            `MAS_IDX_CLK: rsel = {23'h000000, s_q.clk_reg};
            `MAS_IDX_ADD: rsel = {23'h000000, s_q.add_reg};
            `MAS_IDX_STAT: rsel = {22'h000000, wlen, s_q.right, frame, bclk, master};
            default: rsel = 32'h00000000;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.taken = 1'b0;

        // bus slave: ack one cycle, write lands on the acked edge
        s_d.ack = req & ~s_q.ack;
        if (req & ~s_q.ack) begin
            s_d.rdat = rsel;
        end
        if (req & s_q.ack & wb_we_i) begin
            case (idx)
                `MAS_IDX_FMT: begin
                    if (wb_sel_i[0]) begin
                        s_d.fmt_reg[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        s_d.fmt_reg[9:8] = wb_dat_i[9:8];
                    end
                end
                `MAS_IDX_CMP: begin
                    if (wb_sel_i[0]) begin
                        s_d.cmp_reg[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        s_d.cmp_reg[8] = wb_dat_i[8];
                    end
                end
                `MAS_IDX_CLK: begin
                    if (wb_sel_i[0]) begin
                        s_d.clk_reg[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        s_d.clk_reg[8] = wb_dat_i[8];
                    end
                end
                `MAS_IDX_ADD: begin
                    if (wb_sel_i[0]) begin
                        s_d.add_reg[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        s_d.add_reg[8] = wb_dat_i[8];
                    end
                end
                default: begin
                    s_d.rdat = s_q.rdat;
                end
            endcase
        end

        // coefficient select; reserved codes flagged, never passed on
        if (s_q.add_reg[`MAS_ADD_RATE_HI:`MAS_ADD_RATE_LO] <= `MAS_RATE_LAST) begin
            s_d.rate = s_q.add_reg[`MAS_ADD_RATE_HI:`MAS_ADD_RATE_LO];
            s_d.rate_bad = 1'b0;
        end else begin
            s_d.rate_bad = 1'b1;
        end

        // master clocks on core clock edges
        if (master && core_tick) begin
            if (s_q.edge_cnt == `MAS_HALF_FRAME_EDGES - 9'h001) begin
                // frame edge restarts bit clock: last pulse may be short
                s_d.edge_cnt = 9'h000;
                s_d.mframe = ~s_q.mframe;
                s_d.mbclk = 1'b0;
                s_d.bdiv_cnt = 5'h00;
                s_d.dsp_pulse = ~s_q.mframe;
            end else begin
                s_d.edge_cnt = s_q.edge_cnt + 9'h001;
                if (s_q.bdiv_cnt >= bit_half_period(
                        s_q.clk_reg[`MAS_CLK_BDIV_HI:`MAS_CLK_BDIV_LO])) begin
                    s_d.bdiv_cnt = 5'h00;
                    s_d.mbclk = ~s_q.mbclk;
                    if (s_q.mbclk) begin
                        s_d.dsp_pulse = 1'b0;
                    end
                end else begin
                    s_d.bdiv_cnt = s_q.bdiv_cnt + 5'h01;
                end
            end
        end
        if (!master) begin
            s_d.edge_cnt = 9'h000;
            s_d.bdiv_cnt = 5'h00;
            s_d.mbclk = 1'b0;
            s_d.mframe = 1'b0;
            s_d.dsp_pulse = 1'b0;
        end

        // data moves on falls so rises see it stable
        s_d.bclk_prev = bclk;
        if (fall) begin
            s_d.frame_prev = frame;
            s_d.cnt = cnt_n;
            if (new_phase) begin
                s_d.half_len = s_q.cnt + 10'h001;
                s_d.right = (fmt == MAS_FMT_I2S) ? frame :
                            ((fmt == MAS_FMT_DSP) ? 1'b0 : ~frame);
                // one sample per frame, taken at the left phase start
                if ((fmt == MAS_FMT_DSP) ||
                    ((fmt == MAS_FMT_I2S) ? ~frame : frame)) begin
                    s_d.sample = adc_sample;
                    s_d.taken = 1'b1;
                end
            end
            if (active) begin
                s_d.sout = (new_phase && (fmt != MAS_FMT_DSP || s_d.taken)) ?
                           adc_sample[5'h1F - pos[4:0]] :
                           s_q.sample[5'h1F - pos[4:0]];
            end else begin
                s_d.sout = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.fmt_reg <= `MAS_FMT_RESET;
            s_q.cmp_reg <= `MAS_CMP_RESET;
            s_q.clk_reg <= `MAS_CLK_RESET;
            s_q.add_reg <= `MAS_ADD_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign sample_taken = s_q.taken;
    assign serial_sample_out = s_q.sout;
    assign filter_rate_sel = s_q.rate;
    assign filter_rate_reserved = s_q.rate_bad;
    assign bit_clock_o = s_q.mbclk ^ binv;
    assign word_sync_o = (fmt == MAS_FMT_DSP) ? s_q.dsp_pulse : (s_q.mframe ^ spol);
    assign bit_clock_oe_n = ~master;
    assign word_sync_oe_n = ~master;

endmodule

// file: tb/mas_serial_monitor.sv
// checker: bus answer, pin direction, rate, framing
// assumes binding onto the core; shadows landed writes
`timescale 1ns/1ps

module mas_serial_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic bit_clock_i,
    input wire logic bit_clock_o,
    input wire logic bit_clock_oe_n,
    input wire logic word_sync_o,
    input wire logic word_sync_oe_n,
    input wire logic serial_sample_out,
    input wire logic [2:0] filter_rate_sel,
    input wire logic filter_rate_reserved
);
    // ============
    // shadow state
    typedef struct packed {
        logic ms;
        logic binv;
        logic [2:0] rate;
        logic [3:0] bh;
    } mas_mon_state_type;
    mas_mon_state_type s_q, s_d;
    logic wr;
    logic fell_recent;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    // pin sync depth unknown: accept a short window of falls
    assign fell_recent = (s_q.bh[3] & ~s_q.bh[2]) | (s_q.bh[2] & ~s_q.bh[1])
                       | (s_q.bh[1] & ~s_q.bh[0]);

    always_comb begin
        s_d = s_q;
        s_d.bh = {s_q.bh[2:0], bit_clock_i};
        if (wr && wb_sel_i[0] && wb_adr_i == 8'h18) s_d.ms = wb_dat_i[0];
        if (wr && wb_sel_i[1] && wb_adr_i == 8'h10) s_d.binv = wb_dat_i[8];
        if (wr && wb_sel_i[0] && wb_adr_i == 8'h1C) s_d.rate = wb_dat_i[3:1];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) s_q <= '0;
        else s_q <= s_d;
    end

    // ============
    // assertions
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus answer late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_read_unmapped: assert property (wb_ack_o && !wb_we_i
        && (wb_adr_i[7:2] < 6'h04 || wb_adr_i[7:2] > 6'h08) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pin_dir: assert property (s_q.ms == $past(s_q.ms) |-> bit_clock_oe_n == !s_q.ms)
        else $error("pin direction wrong");
    a_pin_pair: assert property (bit_clock_oe_n == word_sync_oe_n)
        else $error("pin pair differs");
    a_rate_follow: assert property (s_q.rate == $past(s_q.rate) && s_q.rate <= 3'h5
        |-> filter_rate_sel == s_q.rate)
        else $error("rate select wrong");
    a_rate_flag: assert property (s_q.rate == $past(s_q.rate)
        |-> filter_rate_reserved == (s_q.rate > 3'h5))
        else $error("rate flag wrong");
    a_sync_bclk_low: assert property (s_q.ms && $past(s_q.ms, 2)
        && s_q.binv == $past(s_q.binv) && $changed(word_sync_o) |-> bit_clock_o == s_q.binv)
        else $error("bit clock high at frame change");
    a_data_after_fall: assert property (!s_q.ms && !$past(s_q.ms, 4)
        && $changed(serial_sample_out) |-> fell_recent)
        else $error("data moved without fall");

    cover property (s_q.ms && $rose(bit_clock_o));
    cover property (!s_q.ms && $rose(serial_sample_out));
    cover property (filter_rate_reserved);
endmodule

bind mas_serial_core mas_serial_monitor u_mon (
    .clk(clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .bit_clock_i(bit_clock_i),
    .bit_clock_o(bit_clock_o), .bit_clock_oe_n(bit_clock_oe_n), .word_sync_o(word_sync_o),
    .word_sync_oe_n(word_sync_oe_n), .serial_sample_out(serial_sample_out),
    .filter_rate_sel(filter_rate_sel), .filter_rate_reserved(filter_rate_reserved)
);

// file: tb/mas_host_port.sv
// host port model: drives bit and frame clocks, captures data
// assumes the bench resolves pin levels; eight clk per half bit
`timescale 1ns/1ps

module mas_host_port (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic left_level,
    input wire logic dsp_mode,
    input wire logic bclk_line,
    input wire logic data_line,
    output logic bclk_drv,
    output logic frame_drv,
    output logic [63:0] frame_word,
    output logic [7:0] frame_count
);
    // ============
    // 64 bit clocks per frame
    typedef struct packed {
        logic [3:0] ph;
        logic [5:0] bitn;
        logic line;
        logic [63:0] cap;
        logic [63:0] word;
        logic [7:0] cnt;
    } mas_host_state_type;
    mas_host_state_type s_q, s_d;

    // clock stands low while stopped; frame edges land on bit clock falls
    assign bclk_drv = run & s_q.ph[3];
    assign frame_drv = dsp_mode ? (s_q.bitn == 6'h00) : (s_q.bitn[5] ^ left_level);
    assign frame_word = s_q.word;
    assign frame_count = s_q.cnt;

    always_comb begin
        s_d = s_q;
        s_d.line = bclk_line;
        if (run) begin
            s_d.ph = s_q.ph + 4'h1;
            if (s_q.ph == 4'hF) s_d.bitn = s_q.bitn + 6'h01;
        end
        if (bclk_line && !s_q.line) begin
            s_d.cap[~s_q.bitn] = data_line;
            if (s_q.bitn == 6'h3F) begin
                s_d.word = {s_q.cap[63:1], data_line};
                s_d.cnt = s_q.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) s_q <= '0;
        else s_q <= s_d;
    end
endmodule

// file: tb/mas_serial_core_tb.sv
// self-checking bench for the serial core and host model
// assumes core, checker and host model compiled first
`timescale 1ns/1ps

module mas_serial_core_tb;
    typedef struct packed {logic [7:0] adr; logic [31:0] val;} mas_reg_row_type;
    typedef struct packed {logic [9:0] fmt; logic byte8;} mas_fmt_row_type;
    localparam logic [31:0] sample_val = 32'hC5A3_96E7;
    logic clk, reset_n, cyc, stb, we, mtick, ptick, run, left_lvl, dsp;
    logic [7:0] adr, fcnt;
    logic [31:0] wdat, rdat, q;
    logic [3:0] sel;
    logic ack, bclk_o, bclk_oe_n, ws_o, ws_oe_n, sout, rate_res, host_bclk, host_ws;
    logic bclk_w, ws_w;
    logic [2:0] rate_sel;
    logic [63:0] fword;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    int i, n;
    int cper [8] = '{32'h2, 32'h3, 32'h4, 32'h6, 32'h8, 32'hC, 32'h10, 32'h18};
    mas_reg_row_type regs [6] = '{'{8'h10, 32'h50}, '{8'h14, 32'h0}, '{8'h18, 32'h140},
        '{8'h1C, 32'h0}, '{8'h00, 32'h0}, '{8'h24, 32'h0}};
    mas_fmt_row_type rows [15] = '{'{10'h008, 1'h0}, '{10'h028, 1'h0}, '{10'h068, 1'h0},
        '{10'h050, 1'h0}, '{10'h040, 1'h0}, '{10'h060, 1'h0}, '{10'h002, 1'h0},
        '{10'h012, 1'h0}, '{10'h248, 1'h0}, '{10'h018, 1'h0}, '{10'h098, 1'h0},
        '{10'h0BA, 1'h0}, '{10'h218, 1'h0}, '{10'h0C8, 1'h0}, '{10'h050, 1'h1}};

    assign bclk_w = bclk_oe_n ? host_bclk : bclk_o;
    assign ws_w = ws_oe_n ? host_ws : ws_o;

    mas_serial_core dut (
        .clk(clk), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
        .master_clock_tick(mtick), .pll_clock_tick(ptick), .adc_sample(sample_val),
        .sample_taken(), .bit_clock_i(bclk_w), .bit_clock_o(bclk_o),
        .bit_clock_oe_n(bclk_oe_n), .word_sync_i(ws_w), .word_sync_o(ws_o),
        .word_sync_oe_n(ws_oe_n), .serial_sample_out(sout), .filter_rate_sel(rate_sel),
        .filter_rate_reserved(rate_res)
    );
    mas_host_port u_host (
        .clk(clk), .reset_n(reset_n), .run(run), .left_level(left_lvl), .dsp_mode(dsp),
        .bclk_line(bclk_w), .data_line(sout), .bclk_drv(host_bclk), .frame_drv(host_ws),
        .frame_word(fword), .frame_count(fcnt)
    );

    // ============
    // clock, watchdog, tasks
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (t = 0; t < 20 && ack !== 1'b1; t++) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (t == 20) chk(64'h1, 64'h0);
    endtask

    // rise-to-rise clk count; zero if stopped
    task automatic span(input logic fs, output int len);
        logic p, s;
        int t, t0;
        len = 0;
        t0 = -1;
        p = 1'b1;
        for (t = 0; t < 3000 && len == 0; t++) begin
            @(posedge clk);
            s = fs ? ws_o : bclk_o;
            if (s === 1'b1 && p === 1'b0) begin
                if (t0 >= 0) len = t - t0;
                t0 = t;
            end
            p = s;
        end
    endtask

    function automatic logic [63:0] exp_frame(input logic [9:0] f, input logic b8);
        int wl, off, s2;
        logic [63:0] w;
        wl = b8 ? 8 : 16 + 4 * int'(f[6:5]) + (f[6:5] == 2'h3 ? 4 : 0);
        if (f[4:3] == 2'h0 && wl == 32) wl = 24;
        w = {sample_val & ~(32'hFFFF_FFFF >> wl), 32'h0};
        off = f[4:3] == 2'h0 ? 32 - wl : f[4:3] == 2'h3 ? int'(!f[7]) : int'(f[4:3] == 2'h2);
        s2 = f[4:3] == 2'h3 ? off + wl : 32 + off;
        exp_frame = 64'h0;
        if (!f[1] || f[9]) exp_frame |= w >> off;
        if (f[1] || f[9]) exp_frame |= w >> s2;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ============
    // main sequence
    initial begin
        reset_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        wdat = 32'h0;
        sel = 4'hF;
        mtick = 1'b0;
        ptick = 1'b0;
        run = 1'b1;
        left_lvl = 1'b0;
        dsp = 1'b0;
        repeat (6) @(posedge clk);
        chk({ack, bclk_oe_n, ws_oe_n, sout}, 4'h6);
        reset_n <= 1'b1;
        @(posedge clk);
        wb(1'b1, 8'h00, 32'hFFFF_FFFF);
        for (i = 0; i < 6; i++) begin
            wb(1'b0, regs[i].adr, 32'h0);
            chk(q, regs[i].val);
        end
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wb(1'b1, 8'h1C, 32'(i) << 1);
            wb(1'b0, 8'h1C, 32'h0);
            chk(q, 32'(i) << 1);
            chk({rate_sel, rate_res}, {i > 5 ? 3'h5 : 3'(i), 1'(i > 5)});
        end
        $display("test rate done");
        for (i = 0; i < 15; i++) begin
            wb(1'b1, 8'h14, {26'h0, rows[i].byte8, 5'h0});
            wb(1'b1, 8'h10, {22'h0, rows[i].fmt});
            wb(1'b0, 8'h10, 32'h0);
            chk(q, {22'h0, rows[i].fmt});
            left_lvl <= rows[i].fmt[4:3] == 2'h2 ? rows[i].fmt[7] : !rows[i].fmt[7];
            dsp <= rows[i].fmt[4:3] == 2'h3;
            n = fcnt;
            for (int t = 0; t < 5000 && fcnt !== 8'(n + 3); t++) @(posedge clk);
            chk(fword, exp_frame(rows[i].fmt, rows[i].byte8));
        end
        $display("test formats done");
        mtick <= 1'b1;
        run <= 1'b0;
        for (i = 0; i < 7; i++) begin
            wb(1'b1, 8'h18, 32'h001 | 32'(i) << 2);
            repeat (80) @(posedge clk);
            span(1'b0, n);
            chk(64'(n), i > 5 ? 64'h40 : 64'h2 << i);
        end
        span(1'b1, n);
        chk(64'(n), 64'h200);
        for (i = 0; i < 8; i++) begin
            wb(1'b1, 8'h18, 32'h001 | 32'(i) << 5);
            repeat (80) @(posedge clk);
            span(1'b0, n);
            chk(64'(n), 64'(cper[i]));
        end
        wb(1'b1, 8'h18, 32'h101);
        span(1'b0, n);
        chk(64'(n), 64'h0);
        ptick <= 1'b1;
        mtick <= 1'b0;
        repeat (80) @(posedge clk);
        span(1'b0, n);
        chk(64'(n), 64'h2);
        wb(1'b1, 8'h18, 32'h115);
        wb(1'b1, 8'h10, 32'h150);
        repeat (1200) @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk({bclk_oe_n, ws_oe_n}, 2'h3);
        wb(1'b0, 8'h18, 32'h0);
        chk(q, 32'h140);
        $display("test master done");
        end_of_test();
    end
endmodule
